// ---- include/ccr_map.vh ----
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// register indices; byte address is four times the index
`define CCR_IDX_CTRL_TWO      8'h61
`define CCR_IDX_RING_MISMATCH 8'h62
`define CCR_IDX_TIP_MISMATCH  8'h63
`define CCR_IDX_DIFF_GAIN     8'h64
`define CCR_IDX_COMMON_GAIN   8'h65
`define CCR_IDX_CURRENT_LIMIT 8'h66
`define CCR_IDX_MONITOR_OFS   8'h67
`define CCR_IDX_ANALOG_OFS    8'h68
`define CCR_IDX_DAC_OFFSET    8'h69
`define CCR_IDX_BALANCE       8'h6a
`define CCR_IDX_IRQ_STATUS    8'h70
`define CCR_IDX_IRQ_MASK      8'h71

// reset values
`define CCR_RST_CTRL_TWO      8'h1f
`define CCR_RST_RING_MISMATCH 8'h10
`define CCR_RST_TIP_MISMATCH  8'h10
`define CCR_RST_DIFF_GAIN     8'h11
`define CCR_RST_COMMON_GAIN   8'h11
`define CCR_RST_CURRENT_LIMIT 8'h08
`define CCR_RST_MONITOR_OFS   8'h88
`define CCR_RST_ANALOG_OFS    8'h00
`define CCR_RST_DAC_OFFSET    8'h00
`define CCR_RST_BALANCE       8'h20
`define CCR_RST_IRQ_STATUS    8'h00
`define CCR_RST_IRQ_MASK      8'h00

// control register two bit positions
`define CCR_BIT_BALANCE_CAL   0
`define CCR_BIT_ADC_CAL       1
`define CCR_BIT_DAC_CAL       2
`define CCR_BIT_MONITOR_TWO   3
`define CCR_BIT_MONITOR_ONE   4
`define CCR_NUM_CAL           5

// field masks of control register two and the result registers
`define CCR_MASK_CTRL_TWO     8'h1f
`define CCR_MASK_FIVE         8'h1f
`define CCR_MASK_FOUR         8'h0f
`define CCR_MASK_ANALOG_OFS   8'h0f
`define CCR_MASK_FULL         8'hff
`define CCR_MASK_BALANCE      8'h3f

`endif

// ---- verilog/ccr_cal_chan.v ----
`timescale 1ns/100ps
// one calibration enable/status bit with its start and finish events
module ccr_cal_chan (
    // clock and reset
    input  wire clk,
    input  wire rst_n,
    // software side
    input  wire sw_write,
    input  wire sw_value,
    // calibration engine side
    input  wire done,
    output reg  run,
    output reg  start,
    output reg  finish
);

    // a write of one wins over a finish in the same cycle so that a
    // restart requested by software is never swallowed
    always @(posedge clk) begin
        if (!rst_n) begin
            run    <= 1'b1;
            start  <= 1'b0;
            finish <= 1'b0;
        end else begin
            start  <= sw_write & sw_value;
            finish <= done & run & ~(sw_write & sw_value);
            if (sw_write) begin
                run <= sw_value;
            end else if (done) begin
                run <= 1'b0;
            end
        end
    end

endmodule // ccr_cal_chan

// ---- verilog/ccr_regs.v ----
`timescale 1ns/100ps
`include "ccr_map.vh"
// Notes on behaviour
// - writing one starts audio dac offset calibration
// - writing one starts audio adc offset calibration
// - writing bit zero starts longitudinal balance calibration
// - calibration bit reads one while enabled/running
// - monitor calibrations at bits four and three
// - five-bit ring mismatch result, read/write
// - five-bit tip mismatch result, read/write
// - five-bit differential gain result, read/write
// - five-bit common mode gain result
// - four-bit current limit result, low nibble
// - two monitor offset nibbles, one high
// - four analog offset bits at three..zero
// - full eight-bit dac offset result
// - six-bit balance result, low bits
module ccr_regs #(
    parameter ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire                  clk,
    input  wire                  rst_n,
    // apb slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [ADDR_WIDTH-1:0] paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    // calibration engine: one done pulse per control bit
    input  wire [4:0]            cal_done,
    // calibration engine: result load, index as on the bus
    input  wire                  res_load,
    input  wire [7:0]            res_index,
    input  wire [7:0]            res_data,
    // calibration run levels and start pulses
    output reg                   monitor_cal_one_go,
    output reg                   monitor_cal_two_go,
    output reg                   audio_dac_offset_cal_go,
    output reg                   audio_adc_offset_cal_go,
    output reg                   longitudinal_balance_cal_go,
    output reg  [4:0]            cal_start,
    // results steering the analog trims
    output reg  [4:0]            ring_mismatch_result,
    output reg  [4:0]            tip_mismatch_result,
    output reg  [4:0]            diff_gain_result,
    output reg  [4:0]            common_gain_result,
    output reg  [3:0]            current_limit_result,
    output reg  [3:0]            monitor_offset_result_one,
    output reg  [3:0]            monitor_offset_result_two,
    output reg                   dac_offset_positive,
    output reg                   dac_offset_negative,
    output reg                   adc_offset_positive,
    output reg                   adc_offset_negative,
    output reg  [7:0]            dac_offset_result,
    output reg  [5:0]            balance_result,
    // interrupt
    output reg                   irq
);

    // register storage
    reg  [7:0] ring_reg;
    reg  [7:0] tip_reg;
    reg  [7:0] diff_reg;
    reg  [7:0] cgain_reg;
    reg  [7:0] ilim_reg;
    reg  [7:0] mon_reg;
    reg  [7:0] aofs_reg;
    reg  [7:0] dofs_reg;
    reg  [7:0] bal_reg;
    reg  [7:0] irq_status;
    reg  [7:0] irq_mask;

    // bus decode
    wire [7:0] index;
    wire       aligned;
    wire       wr_access;
    reg        mapped;
    reg  [7:0] rd_value;
    wire [7:0] wdata;
    wire [4:0] cal_run;
    wire [4:0] cal_start_w;
    wire [4:0] cal_finish;
    wire       ctrl_write;

    assign index     = paddr[9:2];
    assign aligned   = (paddr[1:0] == 2'b00);
    assign wdata     = pwdata[7:0];
    assign wr_access = psel & penable & pready & pwrite & ~pslverr;
    assign ctrl_write = wr_access & (index == `CCR_IDX_CTRL_TWO);

    // one enable/status bit per calibration of control register two
    genvar g;
    generate
        for (g = 0; g < `CCR_NUM_CAL; g = g + 1) begin : cal_bit
            ccr_cal_chan u_chan (
                .clk      (clk),
                .rst_n    (rst_n),
                .sw_write (ctrl_write),
                .sw_value (wdata[g]),
                .done     (cal_done[g]),
                .run      (cal_run[g]),
                .start    (cal_start_w[g]),
                .finish   (cal_finish[g])
            );
        end
    endgenerate

    // run levels go out registered once more; start pulses too
    always @(posedge clk) begin
        if (!rst_n) begin
            monitor_cal_one_go          <= 1'b1;
            monitor_cal_two_go          <= 1'b1;
            audio_dac_offset_cal_go     <= 1'b1;
            audio_adc_offset_cal_go     <= 1'b1;
            longitudinal_balance_cal_go <= 1'b1;
            cal_start                   <= 5'h00;
        end else begin
            monitor_cal_one_go <= cal_run[`CCR_BIT_MONITOR_ONE];
            monitor_cal_two_go <= cal_run[`CCR_BIT_MONITOR_TWO];
            audio_dac_offset_cal_go <= cal_run[`CCR_BIT_DAC_CAL];
            audio_adc_offset_cal_go <= cal_run[`CCR_BIT_ADC_CAL];
            longitudinal_balance_cal_go <= cal_run[`CCR_BIT_BALANCE_CAL];
            cal_start <= cal_start_w;
        end
    end

    // address map and read values; unused bits come back as zero
    always @* begin
        mapped   = 1'b1;
        rd_value = 8'h00;
        case (index)
            `CCR_IDX_CTRL_TWO: begin
                rd_value = {3'b000, cal_run};
            end
            `CCR_IDX_RING_MISMATCH: begin
                rd_value = ring_reg & `CCR_MASK_FIVE;
            end
            `CCR_IDX_TIP_MISMATCH: begin
                rd_value = tip_reg & `CCR_MASK_FIVE;
            end
            `CCR_IDX_DIFF_GAIN: begin
                rd_value = diff_reg & `CCR_MASK_FIVE;
            end
            `CCR_IDX_COMMON_GAIN: begin
                rd_value = cgain_reg & `CCR_MASK_FIVE;
            end
            `CCR_IDX_CURRENT_LIMIT: begin
                rd_value = ilim_reg & `CCR_MASK_FOUR;
            end
            `CCR_IDX_MONITOR_OFS: begin
                rd_value = mon_reg;
            end
            `CCR_IDX_ANALOG_OFS: begin
                rd_value = aofs_reg & `CCR_MASK_ANALOG_OFS;
            end
            `CCR_IDX_DAC_OFFSET: begin
                rd_value = dofs_reg;
            end
            `CCR_IDX_BALANCE: begin
                rd_value = bal_reg & `CCR_MASK_BALANCE;
            end
            `CCR_IDX_IRQ_STATUS: begin
                rd_value = irq_status;
            end
            `CCR_IDX_IRQ_MASK: begin
                rd_value = irq_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        if (!aligned) begin
            mapped   = 1'b0;
            rd_value = 8'h00;
        end
    end

    // apb answer: data and ready registered in the setup cycle, so the
    // access phase always completes in its first cycle; unmapped or
    // unaligned words answer with pslverr and zero data
    always @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // result registers: software writes masked to the field width; an
    // engine load to the same register in the same cycle wins, since
    // the measured value is the newer one
    always @(posedge clk) begin
        if (!rst_n) begin
            ring_reg  <= `CCR_RST_RING_MISMATCH;
            tip_reg   <= `CCR_RST_TIP_MISMATCH;
            diff_reg  <= `CCR_RST_DIFF_GAIN;
            cgain_reg <= `CCR_RST_COMMON_GAIN;
            ilim_reg  <= `CCR_RST_CURRENT_LIMIT;
            mon_reg   <= `CCR_RST_MONITOR_OFS;
            aofs_reg  <= `CCR_RST_ANALOG_OFS;
            dofs_reg  <= `CCR_RST_DAC_OFFSET;
            bal_reg   <= `CCR_RST_BALANCE;
        end else begin
            if (wr_access) begin
                case (index)
                    `CCR_IDX_RING_MISMATCH: begin
                        ring_reg <= wdata & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_TIP_MISMATCH: begin
                        tip_reg <= wdata & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_DIFF_GAIN: begin
                        diff_reg <= wdata & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_COMMON_GAIN: begin
                        cgain_reg <= wdata & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_CURRENT_LIMIT: begin
                        ilim_reg <= wdata & `CCR_MASK_FOUR;
                    end
                    `CCR_IDX_MONITOR_OFS: begin
                        mon_reg <= wdata;
                    end
                    `CCR_IDX_ANALOG_OFS: begin
                        aofs_reg <= wdata & `CCR_MASK_ANALOG_OFS;
                    end
                    `CCR_IDX_DAC_OFFSET: begin
                        dofs_reg <= wdata;
                    end
                    `CCR_IDX_BALANCE: begin
                        bal_reg <= wdata & `CCR_MASK_BALANCE;
                    end
                    default: begin
                        ring_reg <= ring_reg;
                    end
                endcase
            end
            if (res_load) begin
                case (res_index)
                    `CCR_IDX_RING_MISMATCH: begin
                        ring_reg <= res_data & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_TIP_MISMATCH: begin
                        tip_reg <= res_data & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_DIFF_GAIN: begin
                        diff_reg <= res_data & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_COMMON_GAIN: begin
                        cgain_reg <= res_data & `CCR_MASK_FIVE;
                    end
                    `CCR_IDX_CURRENT_LIMIT: begin
                        ilim_reg <= res_data & `CCR_MASK_FOUR;
                    end
                    `CCR_IDX_MONITOR_OFS: begin
                        mon_reg <= res_data;
                    end
                    `CCR_IDX_ANALOG_OFS: begin
                        aofs_reg <= res_data & `CCR_MASK_ANALOG_OFS;
                    end
                    `CCR_IDX_DAC_OFFSET: begin
                        dofs_reg <= res_data;
                    end
                    `CCR_IDX_BALANCE: begin
                        bal_reg <= res_data & `CCR_MASK_BALANCE;
                    end
                    default: begin
                        bal_reg <= bal_reg;
                    end
                endcase
            end
        end
    end

    // result fields out to the analog trims, one flop behind storage;
    // the cycle of latency buys glitch-free trim lines
    always @(posedge clk) begin
        if (!rst_n) begin
            ring_mismatch_result      <= 5'h10;
            tip_mismatch_result       <= 5'h10;
            diff_gain_result          <= 5'h11;
            common_gain_result        <= 5'h11;
            current_limit_result      <= 4'h8;
            monitor_offset_result_one <= 4'h8;
            monitor_offset_result_two <= 4'h8;
            dac_offset_positive       <= 1'b0;
            dac_offset_negative       <= 1'b0;
            adc_offset_positive       <= 1'b0;
            adc_offset_negative       <= 1'b0;
            dac_offset_result         <= 8'h00;
            balance_result            <= 6'h20;
        end else begin
            ring_mismatch_result      <= ring_reg[4:0];
            tip_mismatch_result       <= tip_reg[4:0];
            diff_gain_result          <= diff_reg[4:0];
            common_gain_result        <= cgain_reg[4:0];
            current_limit_result      <= ilim_reg[3:0];
            monitor_offset_result_one <= mon_reg[7:4];
            monitor_offset_result_two <= mon_reg[3:0];
            dac_offset_positive       <= aofs_reg[3];
            dac_offset_negative       <= aofs_reg[2];
            adc_offset_positive       <= aofs_reg[1];
            adc_offset_negative       <= aofs_reg[0];
            dac_offset_result         <= dofs_reg;
            balance_result            <= bal_reg[5:0];
        end
    end

    // sticky finish flags, write one to clear; a finish in the clearing
    // cycle survives because the set term is or'ed in last
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_status <= `CCR_RST_IRQ_STATUS;
            irq_mask   <= `CCR_RST_IRQ_MASK;
            irq        <= 1'b0;
        end else begin
            if (wr_access && index == `CCR_IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~(wdata & `CCR_MASK_CTRL_TWO))
                              | {3'b000, cal_finish};
            end else begin
                irq_status <= irq_status | {3'b000, cal_finish};
            end
            if (wr_access && index == `CCR_IDX_IRQ_MASK) begin
                irq_mask <= wdata & `CCR_MASK_CTRL_TWO;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule // ccr_regs

// ---- verif/ccr_regs_assertions.sv ----
`timescale 1ns/100ps
// port checker for the calibration register bank
module ccr_regs_assertions #(
    parameter ADDR_WIDTH = 12
) (
    // clock and reset
    input wire                  clk,
    input wire                  rst_n,
    // apb slave
    input wire                  psel,
    input wire                  penable,
    input wire                  pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0]           pwdata,
    input wire [31:0]           prdata,
    input wire                  pready,
    input wire                  pslverr,
    // engine loads
    input wire                  res_load,
    input wire [7:0]            res_index,
    input wire [7:0]            res_data,
    // run levels and start pulses
    input wire                  monitor_cal_one_go,
    input wire                  monitor_cal_two_go,
    input wire                  audio_dac_offset_cal_go,
    input wire                  audio_adc_offset_cal_go,
    input wire                  longitudinal_balance_cal_go,
    input wire [4:0]            cal_start,
    // trims
    input wire [4:0]            ring_mismatch_result,
    input wire [3:0]            monitor_offset_result_one,
    input wire [3:0]            monitor_offset_result_two,
    input wire [7:0]            dac_offset_result,
    input wire [5:0]            balance_result
);
    default clocking dflt @(posedge clk); endclocking
    default disable iff (!rst_n);

    // decoded request; engine loads excluded since they win a clash
    wire [7:0] idx = paddr[9:2];
    wire       clean = paddr[1:0] == 2'b00 && paddr[ADDR_WIDTH-1:10] == 0;
    wire       wr_done = psel && penable && pready && pwrite && clean
                         && !res_load;
    wire       wr_ctrl = wr_done && idx == 8'h61;
    wire       bad_idx = idx < 8'h61 || (idx > 8'h6a && idx < 8'h70)
                         || idx > 8'h71;
    wire [4:0] go_vec = {monitor_cal_one_go, monitor_cal_two_go,
        audio_dac_offset_cal_go, audio_adc_offset_cal_go,
        longitudinal_balance_cal_go};

    chk_dac_start: assert property (
        wr_ctrl && pwdata[2] |-> ##2 cal_start[2] && audio_dac_offset_cal_go)
        else $error("dac calibration did not start");
    chk_adc_start: assert property (
        wr_ctrl && pwdata[1] |-> ##2 cal_start[1] && audio_adc_offset_cal_go)
        else $error("adc calibration did not start");
    chk_balance_start: assert property (
        wr_ctrl && pwdata[0] |-> ##2 cal_start[0])
        else $error("balance calibration did not start");
    chk_go_follows: assert property (
        wr_ctrl |-> ##2 go_vec == $past(pwdata[4:0], 2))
        else $error("run levels differ from written control bits");
    chk_monitor_start: assert property (
        wr_ctrl |-> ##2 cal_start[4:3] == $past(pwdata[4:3], 2))
        else $error("monitor start pulses wrong");
    chk_ring_result: assert property (
        wr_done && idx == 8'h62
        |-> ##2 ring_mismatch_result == $past(pwdata[4:0], 2))
        else $error("ring mismatch trim not updated");
    chk_monitor_load: assert property (
        res_load && res_index == 8'h67 |-> ##2
        {monitor_offset_result_one, monitor_offset_result_two}
        == $past(res_data, 2))
        else $error("monitor offset nibbles wrong after load");
    chk_dac_result: assert property (
        wr_done && idx == 8'h69
        |-> ##2 dac_offset_result == $past(pwdata[7:0], 2))
        else $error("dac offset trim not updated");
    chk_balance_result: assert property (
        wr_done && idx == 8'h6a
        |-> ##2 balance_result == $past(pwdata[5:0], 2))
        else $error("balance trim not updated");
    chk_unmapped_error: assert property (
        psel && !penable && clean && bad_idx
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped index not refused");
    chk_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule // ccr_regs_assertions

bind ccr_regs ccr_regs_assertions #(.ADDR_WIDTH(ADDR_WIDTH))
    u_ccr_regs_assertions (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .res_load, .res_index, .res_data,
    .monitor_cal_one_go, .monitor_cal_two_go, .audio_dac_offset_cal_go,
    .audio_adc_offset_cal_go, .longitudinal_balance_cal_go, .cal_start,
    .ring_mismatch_result, .monitor_offset_result_one,
    .monitor_offset_result_two, .dac_offset_result, .balance_result);

// ---- verif/ccr_regs_test.sv ----
`timescale 1ns/100ps
// self-checking bench for the calibration register bank
module ccr_regs_test;
    // design ports; trims packed ring..balance, msb first
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    reg  [4:0]  cal_done = 5'h00;
    reg         res_load = 1'b0;
    reg  [7:0]  res_index = 8'h00;
    reg  [7:0]  res_data = 8'h00;
    wire [4:0]  go_vec;
    wire [4:0]  cal_start;
    wire [49:0] trims;
    wire        irq;
    // bookkeeping
    integer     miscompares = 0;
    integer     num_checks = 0;
    integer     i;
    integer     k;
    reg  [4:0]  last_start = 5'h00;
    reg  [31:0] rd;
    reg         err;
    reg  [15:0] t;
    reg  [7:0]  p;

    always #2 clk = ~clk;

    ccr_regs #(.ADDR_WIDTH(12)) u_ccr_regs (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cal_done(cal_done),
        .res_load(res_load), .res_index(res_index), .res_data(res_data),
        .monitor_cal_one_go(go_vec[4]), .monitor_cal_two_go(go_vec[3]),
        .audio_dac_offset_cal_go(go_vec[2]),
        .audio_adc_offset_cal_go(go_vec[1]),
        .longitudinal_balance_cal_go(go_vec[0]), .cal_start(cal_start),
        .ring_mismatch_result(trims[49:45]),
        .tip_mismatch_result(trims[44:40]), .diff_gain_result(trims[39:35]),
        .common_gain_result(trims[34:30]),
        .current_limit_result(trims[29:26]),
        .monitor_offset_result_one(trims[25:22]),
        .monitor_offset_result_two(trims[21:18]),
        .dac_offset_positive(trims[17]), .dac_offset_negative(trims[16]),
        .adc_offset_positive(trims[15]), .adc_offset_negative(trims[14]),
        .dac_offset_result(trims[13:6]), .balance_result(trims[5:0]), .irq(irq)
    );

    // remember the last start pulse; it lasts one cycle only
    always @(posedge clk) if (cal_start != 5'h00) last_start <= cal_start;

    // reset value and field mask by index
    function [15:0] info(input [7:0] x);
        case (x)
            8'h61: info = 16'h1f1f;
            8'h62, 8'h63: info = 16'h101f;
            8'h64, 8'h65: info = 16'h111f;
            8'h66: info = 16'h080f;
            8'h67: info = 16'h88ff;
            8'h68: info = 16'h000f;
            8'h69: info = 16'h00ff;
            default: info = 16'h203f;
        endcase
    endfunction

    // trim outputs when every result register holds p
    function [49:0] trim_exp(input [7:0] q);
        trim_exp = {{4{q[4:0]}}, q[3:0], q[7:4], q[3:0], q[3:0], q, q[5:0]};
    endfunction

    task check(input string what, input [63:0] exp, input [63:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %s: expected %h, seen %h", what, exp,
                         got);
            end
        end
    endtask

    // one apb transfer; waits for pready, never assumes a latency
    task apb(input wr, input [7:0] x, input [7:0] wd);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= {2'b00, x, 2'b00};
            pwdata <= {24'h0, wd};
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            // no time limit of its own; pready ends this wait, or else the watchdog
            while (pready !== 1'b1) begin
                @(posedge clk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rchk(input [7:0] x, input [7:0] exp);
        begin
            apb(1'b0, x, 8'h00);
            check("read data", {25'h0, exp}, {err, rd});
        end
    endtask

    task load(input [7:0] x, input [7:0] d);
        begin
            @(posedge clk);
            res_load <= 1'b1;
            res_index <= x;
            res_data <= d;
            @(posedge clk);
            res_load <= 1'b0;
        end
    endtask

    task pulse_done(input integer b);
        begin
            @(posedge clk);
            cal_done <= 5'h01 << b;
            @(posedge clk);
            cal_done <= 5'h00;
        end
    endtask

    task results;
        begin
            $display("checks %0d, mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        results;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, then software writes, then engine loads
        for (k = 8'h61; k <= 8'h6a; k = k + 1) begin
            t = info(k[7:0]);
            rchk(k[7:0], t[15:8]);
        end
        check("trims", {20'h84231, 12'h888, 18'h00020}, trims);
        check("run levels", 5'h1f, go_vec);
        for (i = 0; i < 3; i = i + 1) begin
            p = (i == 0) ? 8'hff : (i == 1) ? 8'h5a : 8'ha5;
            for (k = 8'h62; k <= 8'h6a; k = k + 1)
                if (i == 2) load(k[7:0], p);
                else apb(1'b1, k[7:0], p);
            for (k = 8'h62; k <= 8'h6a; k = k + 1) begin
                t = info(k[7:0]);
                rchk(k[7:0], p & t[7:0]);
            end
            check("trims", trim_exp(p), trims);
        end
        // unmapped indices are refused with zero data
        apb(1'b1, 8'h6b, 8'hff);
        check("unmapped", 33'h100000000, {err, rd});
        apb(1'b0, 8'h72, 8'h00);
        check("unmapped", 33'h100000000, {err, rd});
        // abort all, then run each calibration alone to its finish
        apb(1'b1, 8'h61, 8'h00);
        rchk(8'h61, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            apb(1'b1, 8'h61, 8'h01 << i);
            rchk(8'h61, 8'h01 << i);
            check("run levels", 5'h01 << i, go_vec);
            check("start pulse", 5'h01 << i, last_start);
            pulse_done(i);
            rchk(8'h61, 8'h00);
            rchk(8'h70, 8'h01 << i);
            check("irq masked", 1'b0, irq);
            apb(1'b1, 8'h71, 8'h01 << i);
            repeat (2) @(posedge clk);
            check("irq", 1'b1, irq);
            apb(1'b1, 8'h70, 8'h01 << i);
            // a finish while the bit is clear must not raise an event
            pulse_done(i);
            rchk(8'h70, 8'h00);
            check("irq cleared", 1'b0, irq);
            apb(1'b1, 8'h71, 8'h00);
        end
        // clashes: a restart beats a done, an event beats its clear,
        // an engine load beats a bus write to the same register
        apb(1'b1, 8'h61, 8'h01);
        fork
            apb(1'b1, 8'h61, 8'h01);
            begin
                @(posedge clk);
                pulse_done(0);
            end
        join
        rchk(8'h61, 8'h01);
        rchk(8'h70, 8'h00);
        fork
            apb(1'b1, 8'h70, 8'h01);
            pulse_done(0);
        join
        rchk(8'h70, 8'h01);
        rchk(8'h61, 8'h00);
        fork
            apb(1'b1, 8'h62, 8'h03);
            begin
                @(posedge clk);
                load(8'h62, 8'h0c);
            end
        join
        rchk(8'h62, 8'h0c);
        results;
    end
endmodule // ccr_regs_test
